// file: csc_pkg.sv
// shared constants and types for the carrier detect and sleep control block
`default_nettype none
package csc_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int REG_W = 16;
    localparam int CLI_W = 8;
    localparam int PIN_N = 4;
    // register indices, byte address is four times the index
    localparam logic [9:0] IDX_SLEEP = 10'h003;
    localparam logic [9:0] IDX_PIN_BASE = 10'h010;
    localparam logic [9:0] IDX_CD_CFG = 10'h015;
    localparam logic [9:0] IDX_SQL = 10'h016;
    localparam logic [9:0] IDX_BYP = 10'h017;
    localparam logic [9:0] IDX_SWING = 10'h018;
    localparam logic [9:0] IDX_WIN = 10'h020;
    localparam logic [9:0] IDX_DROP = 10'h021;
    localparam logic [9:0] IDX_RISE = 10'h022;
    localparam logic [9:0] IDX_STICKY = 10'h084;
    localparam logic [9:0] IDX_STAT0 = 10'h086;
    localparam logic [9:0] IDX_STAT1 = 10'h087;
    localparam logic [9:0] IDX_CLI = 10'h088;
    // field positions
    localparam int SLP_AUTO = 0;
    localparam int SLP_MANUAL = 1;
    localparam int SLP_MUTE_MODE = 2;
    localparam int SLP_MUTE_LOSS = 3;
    localparam int SLP_DIS_LOSS = 4;
    localparam int BYP_AUTO = 0;
    localparam int BYP_MANUAL = 1;
    localparam int CDC_SQL_INCL = 0;
    localparam int PIN_DIR = 8;
    localparam int ST0_SQL = 0;
    localparam int ST0_SLEEP = 1;
    localparam int ST0_BYP = 2;
    localparam int ST0_LOCK = 3;
    localparam int ST1_PRI = 0;
    localparam int ST1_SEC = 1;
    // reset values
    localparam logic [REG_W-1:0] SLEEP_RST = 16'h0001;
    localparam logic [REG_W-1:0] BYP_RST = 16'h0001;
    localparam logic [REG_W-1:0] CD_CFG_RST = 16'h0000;
    localparam logic [REG_W-1:0] SQL_RST = 16'h0000;
    localparam logic [REG_W-1:0] SWING_RST = 16'h0050;
    localparam logic [REG_W-1:0] WIN_RST = 16'h000E;
    localparam logic [REG_W-1:0] DROP_RST = 16'h0004;
    localparam logic [REG_W-1:0] RISE_RST = 16'h010F;
    localparam logic [7:0] FUNC_NONE = 8'h00;
    localparam logic [7:0] FUNC_SLEEP = 8'h83;
    localparam logic [7:0] FUNC_BYPASS = 8'h84;
    localparam int SLEEP_PIN = 2;
    // timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int CD_SAMPLE_NS = 1600;
    localparam int CD_TICK_CYCLES = (CD_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        CD_ABSENT = 2'b01,
        CD_PRESENT = 2'b10
    } csc_cd_state_e;

    typedef struct packed {
        logic carrierRaw;
        logic rateBelowLimit;
        logic cdrLocked;
        logic [CLI_W-1:0] cableLength;
    } csc_front_s;

    typedef struct packed {
        logic coreSleep;
        logic patternGenEnable;
        logic equalizerBypass;
        logic retimerBypass;
        logic driverMute;
        logic driverDisable;
        logic lockIndication;
    } csc_ctrl_s;
endpackage : csc_pkg
`default_nettype wire

// file: csc_ctrl.sv
// carrier detect, squelch, sleep and bypass control with its register slave
`default_nettype none
module csc_ctrl
    import csc_pkg::*;
#(
    parameter int TICK_CYCLES = CD_TICK_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // axi4-lite write address
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // analog front end and cdr status, asynchronous
    input wire csc_front_s frontIn,
    // general pins
    input wire logic [PIN_N-1:0] pinIn,
    output logic [PIN_N-1:0] pinOut,
    output logic [PIN_N-1:0] pinOe_n,
    // core controls
    output csc_ctrl_s ctrlOut,
    output logic [7:0] sourceSwingCompensation
);
    localparam int FW = $bits(csc_front_s);

    // input synchronisers
    logic [FW+PIN_N-1:0] syncA_reg;
    logic [FW+PIN_N-1:0] syncB_reg;
    csc_front_s front;
    logic [PIN_N-1:0] pinSync;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            syncA_reg <= '0;
            syncB_reg <= '0;
        end else begin
            syncA_reg <= {frontIn, pinIn};
            syncB_reg <= syncA_reg;
        end
    end
    assign front = syncB_reg[FW+PIN_N-1:PIN_N];
    assign pinSync = syncB_reg[PIN_N-1:0];

    // configuration registers
    logic [REG_W-1:0] sleepCtrl_reg;
    logic [REG_W-1:0] cdCfg_reg;
    logic [REG_W-1:0] sqlParam_reg;
    logic [REG_W-1:0] bypCtrl_reg;
    logic [REG_W-1:0] swing_reg;
    logic [REG_W-1:0] sampleWin_reg;
    logic [REG_W-1:0] dropCnt_reg;
    logic [REG_W-1:0] riseCnt_reg;
    logic [8:0] pinCfg_reg [PIN_N];

    // bus slave
    logic awHeld_reg;
    logic wHeld_reg;
    logic [9:0] wIdx_reg;
    logic [DATA_W-1:0] wData_reg;
    logic [3:0] wStrb_reg;
    logic doWrite;
    logic wHit;
    logic [REG_W-1:0] wMerge;

    assign s_axi_awready = !awHeld_reg && !s_axi_bvalid;
    assign s_axi_wready = !wHeld_reg && !s_axi_bvalid;
    assign doWrite = awHeld_reg && wHeld_reg && !s_axi_bvalid;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            awHeld_reg <= 1'b0;
            wIdx_reg <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHeld_reg <= 1'b1;
            wIdx_reg <= s_axi_awaddr[ADDR_W-1:2];
        end else if (doWrite) begin
            awHeld_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wHeld_reg <= 1'b0;
            wData_reg <= '0;
            wStrb_reg <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHeld_reg <= 1'b1;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
        end else if (doWrite) begin
            wHeld_reg <= 1'b0;
        end
    end

    // write hit check
    always_comb begin
        wHit = 1'b0;
        case (wIdx_reg)
            IDX_SLEEP, IDX_CD_CFG, IDX_SQL, IDX_BYP, IDX_SWING, IDX_WIN, IDX_DROP, IDX_RISE: wHit = 1'b1;
            default: wHit = (wIdx_reg >= IDX_PIN_BASE) && (wIdx_reg < IDX_PIN_BASE + 10'(PIN_N));
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wHit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    function automatic logic [REG_W-1:0] mergeBytes(input logic [REG_W-1:0] old);
        mergeBytes = old;
        if (wStrb_reg[0]) mergeBytes[7:0] = wData_reg[7:0];
        if (wStrb_reg[1]) mergeBytes[15:8] = wData_reg[15:8];
    endfunction : mergeBytes

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sleepCtrl_reg <= SLEEP_RST;
            cdCfg_reg <= CD_CFG_RST;
            sqlParam_reg <= SQL_RST;
            bypCtrl_reg <= BYP_RST;
            swing_reg <= SWING_RST;
            sampleWin_reg <= WIN_RST;
            dropCnt_reg <= DROP_RST;
            riseCnt_reg <= RISE_RST;
        end else if (doWrite) begin
            case (wIdx_reg)
                IDX_SLEEP: sleepCtrl_reg <= mergeBytes(sleepCtrl_reg);
                IDX_CD_CFG: cdCfg_reg <= mergeBytes(cdCfg_reg);
                IDX_SQL: sqlParam_reg <= mergeBytes(sqlParam_reg);
                IDX_BYP: bypCtrl_reg <= mergeBytes(bypCtrl_reg);
                IDX_SWING: swing_reg <= mergeBytes(swing_reg);
                IDX_WIN: sampleWin_reg <= mergeBytes(sampleWin_reg);
                IDX_DROP: dropCnt_reg <= mergeBytes(dropCnt_reg);
                IDX_RISE: riseCnt_reg <= mergeBytes(riseCnt_reg);
                default: ;
            endcase
        end
    end

    // general pin configuration, function in [7:0], output direction in [8]
    logic [PIN_N-1:0] pinSleepReq;
    logic [PIN_N-1:0] pinBypassReq;
    logic filteredCarrierPresent;

    genvar gp;
    generate
        for (gp = 0; gp < PIN_N; gp++) begin : g_pin
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    pinCfg_reg[gp] <= {1'b0, (gp == SLEEP_PIN) ? FUNC_SLEEP : FUNC_NONE};
                end else if (doWrite && wIdx_reg == IDX_PIN_BASE + 10'(gp)) begin
                    if (wStrb_reg[0]) pinCfg_reg[gp][7:0] <= wData_reg[7:0];
                    if (wStrb_reg[1]) pinCfg_reg[gp][PIN_DIR] <= wData_reg[PIN_DIR];
                end
            end
            assign pinSleepReq[gp] = !pinCfg_reg[gp][PIN_DIR] && pinCfg_reg[gp][7:0] == FUNC_SLEEP
                && pinSync[gp];
            assign pinBypassReq[gp] = !pinCfg_reg[gp][PIN_DIR] && pinCfg_reg[gp][7:0] == FUNC_BYPASS
                && pinSync[gp];
            assign pinOe_n[gp] = !pinCfg_reg[gp][PIN_DIR];
            assign pinOut[gp] = filteredCarrierPresent;
        end
    endgenerate

    // primary carrier filter
    csc_cd_state_e cdState_reg;
    logic [$clog2(TICK_CYCLES+1)-1:0] tickCnt_reg;
    logic [REG_W-1:0] sampleCnt_reg;
    logic [REG_W-1:0] runCnt_reg;
    logic windowAllPresent_reg;
    logic tick;
    logic windowEnd;
    logic windowOk;
    logic [REG_W-1:0] needCnt;

    assign tick = tickCnt_reg == ($bits(tickCnt_reg))'(TICK_CYCLES - 1);
    // at or past the end, so a window shrunk mid-count still closes
    assign windowEnd = tick && sampleCnt_reg >= sampleWin_reg;
    assign windowOk = windowAllPresent_reg && front.carrierRaw;
    assign needCnt = (cdState_reg == CD_PRESENT) ? dropCnt_reg : riseCnt_reg;
    assign filteredCarrierPresent = cdState_reg == CD_PRESENT;

    // one sample every 1.6us
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tickCnt_reg <= '0;
        end else if (tick) begin
            tickCnt_reg <= '0;
        end else begin
            tickCnt_reg <= tickCnt_reg + 1'b1;
        end
    end

    // window of sampleWin+1 samples; it shows carrier only if every sample does, so one absent sample opposes a present state
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sampleCnt_reg <= '0;
            windowAllPresent_reg <= 1'b1;
        end else if (windowEnd) begin
            sampleCnt_reg <= '0;
            windowAllPresent_reg <= 1'b1;
        end else if (tick) begin
            sampleCnt_reg <= sampleCnt_reg + 1'b1;
            windowAllPresent_reg <= windowOk;
        end
    end

    // consecutive opposing windows change the state
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cdState_reg <= CD_ABSENT;
            runCnt_reg <= '0;
        end else if (windowEnd) begin
            case (cdState_reg)
                CD_ABSENT: begin
                    if (!windowOk) begin
                        runCnt_reg <= '0;
                    end else if (runCnt_reg + 1'b1 >= needCnt) begin
                        cdState_reg <= CD_PRESENT;
                        runCnt_reg <= '0;
                    end else begin
                        runCnt_reg <= runCnt_reg + 1'b1;
                    end
                end
                CD_PRESENT: begin
                    if (windowOk) begin
                        runCnt_reg <= '0;
                    end else if (runCnt_reg + 1'b1 >= needCnt) begin
                        cdState_reg <= CD_ABSENT;
                        runCnt_reg <= '0;
                    end else begin
                        runCnt_reg <= runCnt_reg + 1'b1;
                    end
                end
                default: begin
                    cdState_reg <= CD_ABSENT;
                    runCnt_reg <= '0;
                end
            endcase
        end
    end

    // equalizer bypass
    logic eqBypassed;
    assign eqBypassed = (bypCtrl_reg[BYP_AUTO] ? front.rateBelowLimit
        : bypCtrl_reg[BYP_MANUAL])
        || |pinBypassReq;

    // squelch with hysteresis
    logic squelchActive_reg;
    logic signed [CLI_W+1:0] cliS;
    logic signed [CLI_W+1:0] upperS;
    logic signed [CLI_W+1:0] lowerS;
    logic squelchedCarrierPresent;

    assign cliS = $signed({2'b00, front.cableLength});
    assign upperS = $signed({2'b00, sqlParam_reg[7:0]}) + $signed({2'b00, sqlParam_reg[15:8]});
    assign lowerS = $signed({2'b00, sqlParam_reg[7:0]}) - $signed({2'b00, sqlParam_reg[15:8]});

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            squelchActive_reg <= 1'b0;
        end else if (eqBypassed || !cdCfg_reg[CDC_SQL_INCL]) begin
            squelchActive_reg <= 1'b0;
        end else if (cliS > upperS) begin
            squelchActive_reg <= 1'b1;
        end else if (cliS < lowerS) begin
            squelchActive_reg <= 1'b0;
        end
    end

    assign squelchedCarrierPresent = !(squelchActive_reg && filteredCarrierPresent);

    // sleep decision
    logic lossOfInputSignal;
    logic sleepNow;
    logic lossTrigger;
    assign lossOfInputSignal = !filteredCarrierPresent;
    assign sleepNow = (sleepCtrl_reg[SLP_AUTO] ? lossOfInputSignal
        : sleepCtrl_reg[SLP_MANUAL])
        || |pinSleepReq;
    assign lossTrigger = !squelchedCarrierPresent;

    // core control outputs
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrlOut <= '0;
        end else begin
            ctrlOut.coreSleep <= sleepNow;
            ctrlOut.patternGenEnable <= !sleepNow;
            ctrlOut.equalizerBypass <= eqBypassed;
            ctrlOut.retimerBypass <= eqBypassed;
            ctrlOut.driverMute <= (sleepNow && sleepCtrl_reg[SLP_MUTE_MODE])
                || (lossTrigger && sleepCtrl_reg[SLP_MUTE_LOSS]);
            ctrlOut.driverDisable <= (sleepNow && !sleepCtrl_reg[SLP_MUTE_MODE])
                || (lossTrigger && sleepCtrl_reg[SLP_DIS_LOSS]);
            ctrlOut.lockIndication <= front.cdrLocked && !squelchActive_reg && !sleepNow;
        end
    end
    assign sourceSwingCompensation = swing_reg[7:0];

    // saturating change counters
    logic priLast_reg;
    logic secLast_reg;
    logic [7:0] priChanges_reg;
    logic [7:0] secChanges_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            priLast_reg <= 1'b0;
            secLast_reg <= 1'b1;
            priChanges_reg <= '0;
            secChanges_reg <= '0;
        end else begin
            priLast_reg <= filteredCarrierPresent;
            secLast_reg <= squelchedCarrierPresent;
            if (priLast_reg != filteredCarrierPresent && priChanges_reg != 8'hFF) begin
                priChanges_reg <= priChanges_reg + 1'b1;
            end
            if (secLast_reg != squelchedCarrierPresent && secChanges_reg != 8'hFF) begin
                secChanges_reg <= secChanges_reg + 1'b1;
            end
        end
    end

    // read channel
    logic [9:0] rIdx;
    logic [REG_W-1:0] rValue;
    logic rHit;
    assign rIdx = s_axi_araddr[ADDR_W-1:2];
    assign s_axi_arready = !s_axi_rvalid;

    always_comb begin
        rValue = '0;
        rHit = 1'b1;
        case (rIdx)
            IDX_SLEEP: rValue = sleepCtrl_reg;
            IDX_CD_CFG: rValue = cdCfg_reg;
            IDX_SQL: rValue = sqlParam_reg;
            IDX_BYP: rValue = bypCtrl_reg;
            IDX_SWING: rValue = swing_reg;
            IDX_WIN: rValue = sampleWin_reg;
            IDX_DROP: rValue = dropCnt_reg;
            IDX_RISE: rValue = riseCnt_reg;
            IDX_STICKY: rValue = {secChanges_reg, priChanges_reg};
            IDX_STAT0: begin
                rValue[ST0_SQL] = squelchActive_reg;
                rValue[ST0_SLEEP] = sleepNow;
                rValue[ST0_BYP] = eqBypassed;
                rValue[ST0_LOCK] = ctrlOut.lockIndication;
            end
            IDX_STAT1: begin
                rValue[ST1_PRI] = filteredCarrierPresent;
                rValue[ST1_SEC] = squelchedCarrierPresent;
            end
            IDX_CLI: rValue = {{(REG_W-CLI_W){1'b0}}, front.cableLength};
            default: begin
                if (rIdx >= IDX_PIN_BASE && rIdx < IDX_PIN_BASE + 10'(PIN_N)) begin
                    rValue = {7'h00, pinCfg_reg[rIdx[1:0]]};
                end else begin
                    rHit = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {{(DATA_W-REG_W){1'b0}}, rValue};
            s_axi_rresp <= rHit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule : csc_ctrl
`default_nettype wire

// file: csc_src_model.sv
// upstream source model driving the analog front end status lines
`default_nettype none
module csc_src_model
    import csc_pkg::*;
(
    // clock
    input wire logic clk,
    // source behaviour chosen by the bench
    input wire logic present,
    input wire logic slow,
    input wire logic [CLI_W-1:0] cli,
    // front end status towards the block
    output wire csc_front_s frontOut
);
    // estimate wanders while the cable carries nothing
    logic [CLI_W-1:0] walkReg = 8'h5A;
    logic [1:0] lockReg = 2'h0;
    always @(posedge clk) begin
        walkReg <= walkReg + 8'h3B;
    end
    // retimer locks a few cycles after a fast signal arrives
    always @(posedge clk) begin
        if (present && !slow) begin
            lockReg <= (lockReg == 2'h3) ? lockReg : lockReg + 2'h1;
        end else begin
            lockReg <= 2'h0;
        end
    end
    assign frontOut = '{present, present & slow, lockReg == 2'h3, present ? cli : walkReg};
endmodule : csc_src_model
`default_nettype wire

// file: csc_ctrl_assertions.sv
// port checks for the carrier detect and sleep control block
`default_nettype none
module csc_ctrl_assertions
    import csc_pkg::*;
#(
    parameter int TICK_CYCLES = CD_TICK_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // register read channel
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [DATA_W-1:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // core controls
    input wire csc_ctrl_s ctrlOut,
    input wire logic [7:0] sourceSwingCompensation
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:16] == 16'h0000)
        else $error("read answer missing");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    rd_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    swing_reset_a: assert property ($rose(arst_n) |-> sourceSwingCompensation == 8'h50)
        else $error("swing reset value wrong");
    sleep_gen_a: assert property (ctrlOut.coreSleep |-> !ctrlOut.patternGenEnable)
        else $error("pattern generator on in sleep");
    sleep_drv_a: assert property (ctrlOut.coreSleep |-> ctrlOut.driverMute || ctrlOut.driverDisable)
        else $error("drivers live in sleep");
    byp_retime_a: assert property (ctrlOut.equalizerBypass |-> ctrlOut.retimerBypass)
        else $error("retimer used in bypass");
    lock_sleep_a: assert property (ctrlOut.lockIndication |-> !ctrlOut.coreSleep)
        else $error("lock shown in sleep");
    cover property (ctrlOut.coreSleep ##1 !ctrlOut.coreSleep);
    cover property (!ctrlOut.equalizerBypass ##1 ctrlOut.equalizerBypass);
    cover property (ctrlOut.lockIndication ##1 !ctrlOut.lockIndication);
endmodule : csc_ctrl_assertions
bind csc_ctrl csc_ctrl_assertions #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.clk, .arst_n, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .ctrlOut, .sourceSwingCompensation);
`default_nettype wire

// file: tb_top.sv
// self-checking bench for the carrier detect and sleep control block
`default_nettype none
module tb_top
    import csc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TK = 2;
    localparam int WIN = 1;
    localparam int RISE = 3;
    localparam int DROP = 2;
    localparam logic [9:0] RIDX [8] = '{IDX_SLEEP, IDX_CD_CFG, IDX_SQL, IDX_BYP,
        IDX_SWING, IDX_WIN, IDX_DROP, IDX_RISE};
    localparam logic [31:0] RVAL [8] = '{32'h1, 32'h0, 32'h0, 32'h1, 32'h50, 32'hE, 32'h4, 32'h10F};
    localparam logic [15:0] SLV [5] = '{16'h3, 16'h0, 16'h2, 16'h6, 16'h0};
    localparam logic [6:0] SLX [5] = '{7'h42, 7'h0, 7'h42, 7'h44, 7'h0};
    localparam logic [7:0] CLV [6] = '{8'h60, 8'h48, 8'h38, 8'h37, 8'h48, 8'h49};
    localparam logic SQ [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    logic clk = 1'b0, arst_n = 1'b0, present = 1'b0, slow = 1'b0, prev = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h3;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [PIN_N-1:0] pinIn = 4'h0, pinOut, pinOe_n;
    logic [CLI_W-1:0] cli = 8'h00;
    logic [7:0] sourceSwingCompensation;
    csc_front_s frontIn;
    csc_ctrl_s ctrlOut;
    int miscompares = 0, tests_run = 0, tog = 0;
    csc_ctrl #(.TICK_CYCLES(TK)) i_dut (.clk, .arst_n, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .frontIn, .pinIn, .pinOut, .pinOe_n,
        .ctrlOut, .sourceSwingCompensation);
    csc_src_model i_src (.clk, .present, .slow, .cli, .frontOut(frontIn));
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask : chk
    task automatic results();
        if (miscompares == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results
    // handshakes are judged at the falling edge, acted on at the next rising edge
    task automatic wr(input logic [9:0] i, input logic [15:0] d, input logic [1:0] er = RESP_OKAY);
        logic ta, tw, tb;
        logic [1:0] rsp;
        @(posedge clk);
        s_axi_awaddr <= {i, 2'b00};
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge clk);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            tb = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end while (!tb);
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, er}, {30'h0, rsp});
    endtask : wr
    task automatic rd(input logic [9:0] i, input logic [31:0] e, input logic [1:0] er = RESP_OKAY);
        logic ta, tr;
        logic [33:0] got;
        @(posedge clk);
        s_axi_araddr <= {i, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge clk);
            ta = s_axi_arvalid & s_axi_arready;
            tr = s_axi_rvalid & s_axi_rready;
            got = {s_axi_rresp, s_axi_rdata};
            @(posedge clk);
            if (ta) s_axi_arvalid <= 1'b0;
        end while (!tr);
        s_axi_rready <= 1'b0;
        chk($sformatf("reg %h", i), e, got[31:0]);
        chk("rresp", {30'h0, er}, {30'h0, got[33:32]});
    endtask : rd
    task automatic ctl(input logic [6:0] e, input logic [6:0] m);
        repeat (6) @(posedge clk);
        chk("ctrl", 32'(e), 32'(ctrlOut & m));
    endtask : ctl
    // time from a carrier change to the filtered detect following it
    task automatic edge_time(input logic v, input int cnt);
        int n;
        int t;
        n = 0;
        t = TK * (WIN + 1) * cnt;
        present <= v;
        while (pinOut[0] !== v && n < 400) begin
            @(negedge clk);
            n++;
        end
        chk("cd time", 32'h1, 32'(n >= t - TK && n <= t + 2 * TK * (WIN + 1) + 4));
        @(posedge clk);
    endtask : edge_time
    initial begin
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        results();
    end
    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            rd(RIDX[k], RVAL[k]);
        end
        chk("swing", 32'h50, 32'(sourceSwingCompensation));
        chk("pin dir", 32'hF, 32'(pinOe_n));
        rd(10'h3FF, 32'h0, RESP_SLVERR);
        wr(10'h3FF, 16'h1234, RESP_SLVERR);
        wr(IDX_STICKY, 16'h00FF, RESP_SLVERR);
        ctl(7'h42, 7'h62);
        for (int k = 0; k < 5; k++) begin
            wr(IDX_SLEEP, SLV[k]);
            ctl(SLX[k], 7'h46);
        end
        pinIn[2] <= 1'b1;
        ctl(7'h40, 7'h40);
        pinIn[2] <= 1'b0;
        ctl(7'h00, 7'h40);
        wr(IDX_SLEEP, 16'h0001);
        wr(IDX_WIN, 16'(WIN));
        wr(IDX_RISE, 16'(RISE));
        wr(IDX_DROP, 16'(DROP));
        edge_time(1'b1, RISE);
        rd(IDX_STAT0, 32'h8);
        rd(IDX_STAT1, 32'h3);
        wr(IDX_SLEEP, 16'h0003);
        ctl(7'h00, 7'h40);
        edge_time(1'b0, DROP);
        ctl(7'h40, 7'h60);
        edge_time(1'b1, RISE);
        slow <= 1'b1;
        ctl(7'h18, 7'h18);
        slow <= 1'b0;
        ctl(7'h00, 7'h18);
        wr(IDX_BYP, 16'h0002);
        ctl(7'h18, 7'h18);
        wr(IDX_BYP, 16'h0000);
        wr(IDX_PIN_BASE, 16'h0084);
        ctl(7'h00, 7'h18);
        pinIn[0] <= 1'b1;
        ctl(7'h18, 7'h18);
        chk("pin dir", 32'hF, 32'(pinOe_n));
        pinIn[0] <= 1'b0;
        wr(IDX_BYP, 16'h0001);
        wr(IDX_SQL, 16'h0840);
        cli <= CLV[0];
        ctl(7'h01, 7'h01);
        rd(IDX_STAT0, 32'h8);
        rd(IDX_CLI, 32'h60);
        wr(IDX_CD_CFG, 16'h0001);
        for (int k = 0; k < 6; k++) begin
            cli <= CLV[k];
            tog += int'(SQ[k] != prev);
            prev = SQ[k];
            ctl({6'h00, !SQ[k]}, 7'h01);
            rd(IDX_STAT0, SQ[k] ? 32'h1 : 32'h8);
            rd(IDX_STAT1, SQ[k] ? 32'h1 : 32'h3);
        end
        wr(IDX_SLEEP, 16'h0009);
        ctl(7'h04, 7'h44);
        slow <= 1'b1;
        ctl(7'h00, 7'h04);
        rd(IDX_STAT0, 32'h4);
        rd(IDX_STICKY, {16'h0000, 8'(tog + 1), 8'h03});
        results();
    end
endmodule : tb_top
`default_nettype wire
